// >>> design/pmbus_status_consts.vh
// Purpose: Command codes, field positions, reset values and timing for the status bank
// Assumes: Byte-wide command port behind a PMBus engine
// Notes:   Included by every design file
`ifndef PMBUS_STATUS_CONSTS_VH
`define PMBUS_STATUS_CONSTS_VH
`define CMD_RISE_TIME      8'h61
`define CMD_SUMMARY_BYTE   8'h78
`define CMD_SUMMARY_WORD   8'h79
`define CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS     8'h7A
`define CMD_IOUT_FLAGS     8'h7B
`define CMD_TEMP_FLAGS     8'h7D
`define CMD_COMM_FLAGS     8'h7E
`define CMD_VENDOR_FLAGS   8'h80
`define CMD_SAVE_ALL       8'h15
`define RISE_EXPONENT      5'h1C
`define RISE_MANT_RESET    8'h2B
`define SB_OFF             6
`define SB_OV              5
`define SB_OC              4
`define SB_VINUV           3
`define SB_TEMP            2
`define SB_CML             1
`define SB_OTHER           0
`define SW_OUTPUT_VOLTAGE_SUMMARY            7
`define SW_IOUT            6
`define SW_VENDOR          4
`define SW_PGOOD           3
`define VF_OV              7
`define VF_UV              4
`define IF_OC              7
`define IF_OCW             5
`define TF_OT              7
`define TF_OTW             6
`define CF_CMD             7
`define CF_DATA            6
`define CF_PEC             5
`define CF_MEM             4
`define CF_OTHER           1
`define MF_TSD             7
`define SETTING_COUNT      8
`define RAMP_STEP_US       100
`define MCLK_MHZ           250
`endif

// >>> design/rise_time_snap.v
// Purpose: Snaps a rise-time mantissa (units of 1/16 ms) to the nearest setting
// Assumes: Mantissa in sixteenths of a millisecond, exponent fixed at -4
// Notes:   Zero passes as zero; ties pick the lower setting
`timescale 1ns/1ps
`include "pmbus_status_consts.vh"
module rise_time_snap (
    input  wire [7:0] rawMant,
    output reg  [7:0] snapMant
);
    // Settings in sixteenths: 0.6 .. 9.0 ms, nearest representable codes
    function [7:0] setting;
        input [2:0] idx;
        begin
            case (idx)
                3'd0:    setting = 8'h0A;
                3'd1:    setting = 8'h0E;
                3'd2:    setting = 8'h13;
                3'd3:    setting = 8'h1B;
                3'd4:    setting = 8'h2B;
                3'd5:    setting = 8'h43;
                3'd6:    setting = 8'h60;
                default: setting = 8'h90;
            endcase
        end
    endfunction

    function [7:0] absDiff;
        input [7:0] a;
        input [7:0] b;
        begin
            absDiff = (a > b) ? (a - b) : (b - a);
        end
    endfunction

    integer i;
    reg [7:0] bestDiff;
    always @* begin
        snapMant = setting(3'd0);
        bestDiff = absDiff(rawMant, setting(3'd0));
        for (i = 1; i < `SETTING_COUNT; i = i + 1) begin
            if (absDiff(rawMant, setting(i[2:0])) < bestDiff) begin
                bestDiff = absDiff(rawMant, setting(i[2:0]));
                snapMant = setting(i[2:0]);
            end
        end
        if (rawMant == 8'h00) begin
            snapMant = 8'h00;
        end
    end
endmodule // rise_time_snap

// >>> design/ref_ramp.v
// Purpose: Slews the reference toward its target at the rise-time rate
// Assumes: Target in arbitrary reference codes, one code step every (riseMant >> 3) + 1 ticks
// Notes:   Zero rise time jumps straight to target
`timescale 1ns/1ps
`include "pmbus_status_consts.vh"
module ref_ramp #(
    parameter REF_W = 12,
    parameter TICK_CYCLES = `RAMP_STEP_US * `MCLK_MHZ
) (
    input  wire             mclk,
    input  wire             rstn,
    input  wire             clkEn,
    input  wire             softStart,
    input  wire [7:0]       riseMant,
    input  wire [REF_W-1:0] refTarget,
    output reg  [REF_W-1:0] refLevel
);
    reg [15:0] tickCnt_q;
    reg [7:0]  stepCnt_q;
    wire       tick = (tickCnt_q == TICK_CYCLES[15:0] - 16'h0001);
    // Larger mantissa means more ticks between steps
    wire       stepNow = tick && (stepCnt_q >= (riseMant >> 3));
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_q <= 16'h0000;
            stepCnt_q <= 8'h00;
            refLevel  <= {REF_W{1'b0}};
        end else if (clkEn) begin
            tickCnt_q <= tick ? 16'h0000 : tickCnt_q + 16'h0001;
            if (!softStart || riseMant == 8'h00) begin
                refLevel  <= refTarget;
                stepCnt_q <= 8'h00;
            end else if (stepNow) begin
                stepCnt_q <= 8'h00;
                if (refLevel < refTarget) begin
                    refLevel <= refLevel + {{(REF_W-1){1'b0}}, 1'b1};
                end else if (refLevel > refTarget) begin
                    refLevel <= refLevel - {{(REF_W-1){1'b0}}, 1'b1};
                end
            end else if (tick) begin
                stepCnt_q <= stepCnt_q + 8'h01;
            end
        end
    end
endmodule // ref_ramp

// >>> design/pmbus_status_regs.v
// What this block does
// - Writes snap to nearest supported rise time
// - Zero rise time: reference jumps, no ramp
// - Rise time sets soft-start reference slew
// - Linear word, exponent -4, mantissa reset 43
// - Save-all copies rise time to memory
// - 78h returns seven fault summary bits
// - Output-off bit while converter disabled
// - Overvoltage, overcurrent, input-undervoltage summary bits
// - Temperature bit on external fault/warning
// - Comm/memory/logic bit from comm flags
// - Other bit for output undervoltage and overcurrent warning
// - 79h low byte equals summary byte
// - High byte: bits 7,6,4,3 used
// - Voltage summary from voltage flags
// - Current summary from current flags only
// - Vendor summary on thermal shutdown
// - Power-good bit until high-to-low seen
// - 7Ah bit 7 output overvoltage
// - 7Ah bit 4 output undervoltage
// - 7Bh bit 7 overcurrent fault
// - 7Bh bit 5 overcurrent warning
// - Temperature flags bits 7 and 6
// - Comm flags: command, data, PEC, memory, other
//
// Purpose: Status and rise-time bank behind a PMBus command engine
// Assumes: Engine delivers command code, write strobes and byte lane
// Notes:   Fault inputs are pins and are synchronised here
`timescale 1ns/1ps
`include "pmbus_status_consts.vh"
module pmbus_status_regs #(
    parameter REF_W = 12
) (
    input  wire             mclk,
    input  wire             rstn,
    input  wire             clkEn,
    input  wire [7:0]       cmdCode,
    input  wire             wrStrobe,
    input  wire             wrHigh,
    input  wire [7:0]       wrData,
    input  wire             rdStrobe,
    input  wire             rdHigh,
    output reg  [7:0]       rdData,
    output reg              rdValid,
    output reg              rdUnsupported,
    input  wire             convEnable,
    input  wire             vOutOv,
    input  wire             vOutUv,
    input  wire             iOutOc,
    input  wire             iOutOcw,
    input  wire             vInUv,
    input  wire             extOt,
    input  wire             extOtw,
    input  wire             thermalShutdown,
    input  wire             powerGood,
    input  wire             badCommand,
    input  wire             badData,
    input  wire             pecFail,
    input  wire             memoryFault,
    input  wire             otherCommFault,
    input  wire             clearFaults,
    input  wire             softStart,
    input  wire [REF_W-1:0] refTarget,
    output wire [REF_W-1:0] refLevel,
    output reg              nvmSave,
    output reg  [15:0]      nvmRiseWord
);
    localparam NPIN     = 15;
    // Bit positions in the synchronised pin vector
    localparam PIN_EN   = 14;
    localparam PIN_OV   = 13;
    localparam PIN_UV   = 12;
    localparam PIN_OC   = 11;
    localparam PIN_OCW  = 10;
    localparam PIN_VIN  = 9;
    localparam PIN_OT   = 8;
    localparam PIN_OTW  = 7;
    localparam PIN_TSD  = 6;
    localparam PIN_PG   = 5;
    localparam PIN_CMD  = 4;
    localparam PIN_DATA = 3;
    localparam PIN_PEC  = 2;
    localparam PIN_MEM  = 1;
    localparam PIN_OTHC = 0;

    // Two-stage synchroniser for the asynchronous fault pins
    wire [NPIN-1:0] pinRaw = {convEnable, vOutOv, vOutUv, iOutOc, iOutOcw, vInUv,
                              extOt, extOtw, thermalShutdown, powerGood, badCommand,
                              badData, pecFail, memoryFault, otherCommFault};
    reg  [NPIN-1:0] syncA_q;
    reg  [NPIN-1:0] syncB_q;
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : gSync
            always @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    syncA_q[g] <= 1'b0;
                    syncB_q[g] <= 1'b0;
                end else if (clkEn) begin
                    syncA_q[g] <= pinRaw[g];
                    syncB_q[g] <= syncA_q[g];
                end
            end
        end
    endgenerate
    wire sEn   = syncB_q[PIN_EN];
    wire sOv   = syncB_q[PIN_OV];
    wire sUv   = syncB_q[PIN_UV];
    wire sOc   = syncB_q[PIN_OC];
    wire sOcw  = syncB_q[PIN_OCW];
    wire sVin  = syncB_q[PIN_VIN];
    wire sOt   = syncB_q[PIN_OT];
    wire sOtw  = syncB_q[PIN_OTW];
    wire sTsd  = syncB_q[PIN_TSD];
    wire sPg   = syncB_q[PIN_PG];
    wire sCmd  = syncB_q[PIN_CMD];
    wire sData = syncB_q[PIN_DATA];
    wire sPec  = syncB_q[PIN_PEC];
    wire sMem  = syncB_q[PIN_MEM];
    wire sOthC = syncB_q[PIN_OTHC];

    // Latched detail flags; a new event wins over a clear in the same cycle
    reg  [7:0] voutFlags_q;
    reg  [7:0] ioutFlags_q;
    reg  [7:0] tempFlags_q;
    reg  [7:0] commFlags_q;
    reg  [7:0] vendorFlags_q;
    reg        pgFell_q;
    reg        pgPrev_q;
    reg  [7:0] voutEv;
    reg  [7:0] ioutEv;
    reg  [7:0] tempEv;
    reg  [7:0] commEv;
    reg  [7:0] vendorEv;
    always @* begin
        voutEv = 8'h00;
        ioutEv = 8'h00;
        tempEv = 8'h00;
        commEv = 8'h00;
        vendorEv = 8'h00;
        voutEv[`VF_OV]   = sOv;
        voutEv[`VF_UV]   = sUv;
        ioutEv[`IF_OC]   = sOc;
        ioutEv[`IF_OCW]  = sOcw;
        tempEv[`TF_OT]   = sOt;
        tempEv[`TF_OTW]  = sOtw;
        commEv[`CF_CMD]  = sCmd;
        commEv[`CF_DATA] = sData;
        commEv[`CF_PEC]  = sPec;
        commEv[`CF_MEM]  = sMem;
        commEv[`CF_OTHER] = sOthC;
        vendorEv[`MF_TSD] = sTsd;
    end

    // Rise time mantissa, snapped on write
    reg  [7:0] riseMant_q;
    reg  [7:0] riseLowPend_q;
    wire [7:0] snapped;
    rise_time_snap uSnap (
        .rawMant  (riseLowPend_q),
        .snapMant (snapped)
    );
    reg        snapPend_q;

    wire isRiseWr = wrStrobe && (cmdCode == `CMD_RISE_TIME);
    wire isSave   = wrStrobe && (cmdCode == `CMD_SAVE_ALL);
    wire pgFall   = pgPrev_q && !sPg;

    // Flag next values; a new event wins over a clear in the same cycle
    function [7:0] keptFlags;
        input [7:0] flags;
        input       clr;
        begin
            keptFlags = clr ? 8'h00 : flags;
        end
    endfunction

    reg  [7:0] voutFlags_d;
    reg  [7:0] ioutFlags_d;
    reg  [7:0] tempFlags_d;
    reg  [7:0] commFlags_d;
    reg  [7:0] vendorFlags_d;
    reg        pgFell_d;
    always @* begin
        voutFlags_d   = keptFlags(voutFlags_q, clearFaults) | voutEv;
        ioutFlags_d   = keptFlags(ioutFlags_q, clearFaults) | ioutEv;
        tempFlags_d   = keptFlags(tempFlags_q, clearFaults) | tempEv;
        commFlags_d   = keptFlags(commFlags_q, clearFaults) | commEv;
        vendorFlags_d = keptFlags(vendorFlags_q, clearFaults) | vendorEv;
        pgFell_d      = (pgFell_q && !clearFaults) || pgFall;
    end

    // Mantissa takes the snapped value one cycle after the write
    reg  [7:0] riseMant_d;
    always @* begin
        riseMant_d = riseMant_q;
        if (snapPend_q) begin
            riseMant_d = snapped;
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            voutFlags_q   <= 8'h00;
            ioutFlags_q   <= 8'h00;
            tempFlags_q   <= 8'h00;
            commFlags_q   <= 8'h00;
            vendorFlags_q <= 8'h00;
            pgFell_q      <= 1'b0;
            pgPrev_q      <= 1'b0;
            riseMant_q    <= `RISE_MANT_RESET;
            riseLowPend_q <= 8'h00;
            snapPend_q    <= 1'b0;
            nvmSave       <= 1'b0;
            nvmRiseWord   <= 16'h0000;
        end else if (clkEn) begin
            pgPrev_q      <= sPg;
            voutFlags_q   <= voutFlags_d;
            ioutFlags_q   <= ioutFlags_d;
            tempFlags_q   <= tempFlags_d;
            commFlags_q   <= commFlags_d;
            vendorFlags_q <= vendorFlags_d;
            pgFell_q      <= pgFell_d;
            // Upper mantissa bits and exponent are not writable
            if (isRiseWr && !wrHigh) begin
                riseLowPend_q <= wrData;
                snapPend_q    <= 1'b1;
            end else begin
                snapPend_q <= 1'b0;
            end
            riseMant_q <= riseMant_d;
            nvmSave <= isSave;
            if (isSave) begin
                nvmRiseWord <= {`RISE_EXPONENT, 3'b000, riseMant_q};
            end
        end
    end

    // Ramp follows the live mantissa, so a new rise time applies at once
    ref_ramp #(
        .REF_W (REF_W)
    ) uRamp (
        .mclk      (mclk),
        .rstn      (rstn),
        .clkEn     (clkEn),
        .softStart (softStart),
        .riseMant  (riseMant_q),
        .refTarget (refTarget),
        .refLevel  (refLevel)
    );

    // Summary bits, each the OR of what it covers, except off and power-good, which are inverted single signals
    reg [7:0] sumByte;
    reg [7:0] sumHigh;
    always @* begin
        sumByte = 8'h00;
        sumHigh = 8'h00;
        sumByte[`SB_OFF]   = !sEn;
        sumByte[`SB_OV]    = voutFlags_q[`VF_OV];
        sumByte[`SB_OC]    = ioutFlags_q[`IF_OC];
        sumByte[`SB_VINUV] = sVin;
        sumByte[`SB_TEMP]  = |tempFlags_q;
        sumByte[`SB_CML]   = |commFlags_q;
        sumByte[`SB_OTHER] = voutFlags_q[`VF_UV] | ioutFlags_q[`IF_OCW];
        sumHigh[`SW_OUTPUT_VOLTAGE_SUMMARY]   = |voutFlags_q;
        sumHigh[`SW_IOUT]   = |ioutFlags_q;
        sumHigh[`SW_VENDOR] = |vendorFlags_q;
        sumHigh[`SW_PGOOD]  = !pgFell_q;
    end

    // Read port: one cycle after the strobe; writes to status codes ignored
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdData        <= 8'h00;
            rdValid       <= 1'b0;
            rdUnsupported <= 1'b0;
        end else if (clkEn) begin
            rdValid       <= rdStrobe;
            rdUnsupported <= 1'b0;
            // Read byte holds between reads; only a strobe reloads it
            if (rdStrobe) begin
                case (cmdCode)
                    `CMD_RISE_TIME:    rdData <= rdHigh ?
                                           {`RISE_EXPONENT, 3'b000} : riseMant_q;
                    `CMD_SUMMARY_BYTE: rdData <= sumByte;
                    `CMD_SUMMARY_WORD: rdData <= rdHigh ? sumHigh : sumByte;
                    `CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS:   rdData <= voutFlags_q;
                    `CMD_IOUT_FLAGS:   rdData <= ioutFlags_q;
                    `CMD_TEMP_FLAGS:   rdData <= tempFlags_q;
                    `CMD_COMM_FLAGS:   rdData <= commFlags_q;
                    `CMD_VENDOR_FLAGS: rdData <= vendorFlags_q;
                    default: begin
                        rdData        <= 8'h00;
                        rdUnsupported <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // pmbus_status_regs

// >>> verification/pmbus_status_regs_monitor.sv
// Purpose: Port-level checks of the status and rise-time bank
// Assumes: Reads answered one cycle after a taken strobe
// Notes:   Bound to every pmbus_status_regs instance
`timescale 1ns/1ps
`include "pmbus_status_consts.vh"
module pmbus_status_regs_monitor (
    input wire        mclk,
    input wire        rstn,
    input wire        clkEn,
    input wire [7:0]  cmdCode,
    input wire        wrStrobe,
    input wire        rdStrobe,
    input wire        rdHigh,
    input wire [7:0]  rdData,
    input wire        rdValid,
    input wire        rdUnsupported,
    input wire        convEnable,
    input wire        nvmSave,
    input wire [15:0] nvmRiseWord
);
    wire rdTake = rdStrobe && clkEn;
    wire wrTake = wrStrobe && clkEn;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    AST_READ_ANSWER: assert property (rdTake |=> rdValid)
        else $error("read strobe not answered next cycle");
    AST_READ_CAUSE: assert property (rdValid |-> $past(rdTake))
        else $error("read answer without a taken strobe");
    AST_UNSUP_ZERO: assert property (rdUnsupported |-> rdValid && rdData == 8'h00)
        else $error("unsupported read not zero");
    AST_RISE_HIGH: assert property (rdTake && cmdCode == `CMD_RISE_TIME && rdHigh
        |=> rdData == 8'hE0) else $error("rise word high byte wrong");
    AST_WORD_UNUSED: assert property (rdTake && cmdCode == `CMD_SUMMARY_WORD && rdHigh
        |=> rdData[5] == 1'b0 && rdData[2:0] == 3'h0) else $error("word unused bits set");
    AST_BYTE_BIT7: assert property (rdTake && !rdHigh && (cmdCode == `CMD_SUMMARY_BYTE
        || cmdCode == `CMD_SUMMARY_WORD) |=> !rdData[7]) else $error("summary bit 7 set");
    AST_OUTPUT_VOLTAGE_SUMMARY_UNUSED: assert property (rdTake && cmdCode == `CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS
        |=> (rdData & 8'h6F) == 8'h00) else $error("voltage flags unused bits set");
    AST_IOUT_UNUSED: assert property (rdTake && cmdCode == `CMD_IOUT_FLAGS
        |=> (rdData & 8'h5F) == 8'h00) else $error("current flags unused bits set");
    AST_SAVE: assert property (wrTake && cmdCode == `CMD_SAVE_ALL
        |=> nvmSave && nvmRiseWord[15:8] == 8'hE0) else $error("save not issued");
    AST_OFF_BIT: assert property ((!convEnable)[*4] ##0 (rdTake && !rdHigh
        && cmdCode == `CMD_SUMMARY_BYTE) |=> rdData[6]) else $error("output-off bit clear");
endmodule // pmbus_status_regs_monitor
bind pmbus_status_regs pmbus_status_regs_monitor pmbus_status_regs_monitor_inst (
    .mclk(mclk), .rstn(rstn), .clkEn(clkEn), .cmdCode(cmdCode), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdHigh(rdHigh), .rdData(rdData), .rdValid(rdValid),
    .rdUnsupported(rdUnsupported), .convEnable(convEnable), .nvmSave(nvmSave),
    .nvmRiseWord(nvmRiseWord));

// >>> verification/pmbus_host_model.sv
// Purpose: Command engine side that issues register reads and writes
// Assumes: Strobes taken on the rising edge, driven from the falling edge
// Notes:   A read with no answer returns unknowns
`timescale 1ns/1ps
module pmbus_host_model (
    input  wire        mclk,
    input  wire  [7:0] rdData,
    input  wire        rdValid,
    input  wire        rdUnsupported,
    output logic [7:0] cmdCode,
    output logic       wrStrobe,
    output logic       wrHigh,
    output logic [7:0] wrData,
    output logic       rdStrobe,
    output logic       rdHigh
);
    initial begin
        cmdCode = 8'h00;
        wrStrobe = 1'b0;
        wrHigh = 1'b0;
        wrData = 8'h00;
        rdStrobe = 1'b0;
        rdHigh = 1'b0;
    end
    task automatic wr(input logic [7:0] cmd, input logic hi, input logic [7:0] data);
        @(negedge mclk);
        cmdCode = cmd;
        wrHigh = hi;
        wrData = data;
        wrStrobe = 1'b1;
        @(negedge mclk);
        wrStrobe = 1'b0;
    endtask
    task automatic rd(input logic [7:0] cmd, input logic hi, output logic [7:0] data,
                      output logic unsup);
        @(negedge mclk);
        cmdCode = cmd;
        rdHigh = hi;
        rdStrobe = 1'b1;
        @(negedge mclk);
        rdStrobe = 1'b0;
        data = 8'hxx;
        unsup = 1'bx;
        // Answer stands from the taking edge to the next one; look mid-cycle
        for (int i = 0; i < 4; i++) begin
            if (rdValid === 1'b1) begin
                data = rdData;
                unsup = rdUnsupported;
                break;
            end
            @(negedge mclk);
        end
    endtask
endmodule // pmbus_host_model

// >>> verification/tb_pmbus_status_regs.sv
// Purpose: Self-checking bench for the status and rise-time bank
// Assumes: Fault pins are seen four cycles after they change
// Notes:   Ramp check runs one full step interval
`timescale 1ns/1ps
`include "pmbus_status_consts.vh"
module tb_pmbus_status_regs;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        convEnable = 1'b1;
    logic        powerGood = 1'b1;
    logic        clearFaults = 1'b0;
    logic        softStart = 1'b0;
    logic [12:0] pins = 13'h0000;
    logic [11:0] refTarget = 12'h064;
    wire  [7:0]  cmdCode, wrData, rdData;
    wire         wrStrobe, wrHigh, rdStrobe, rdHigh, rdValid, rdUnsupported, nvmSave;
    wire  [11:0] refLevel;
    wire  [15:0] nvmRiseWord;
    int          n_mismatch = 0;
    int          n_compared = 0;
    logic [7:0]  got;
    logic        uns;
    logic [7:0]  snapIn [7] = '{8'h05, 8'h00, 8'h0C, 8'hFF, 8'h50, 8'h17, 8'h2B};
    logic [7:0]  snapOut [7] = '{8'h0A, 8'h00, 8'h0A, 8'h90, 8'h43, 8'h13, 8'h2B};
    logic [7:0]  sumB [13] = '{8'h20, 8'h01, 8'h10, 8'h01, 8'h08, 8'h04, 8'h04, 8'h00,
                               8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
    logic [7:0]  sumH [13] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h10,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  detC [13] = '{8'h7A, 8'h7A, 8'h7B, 8'h7B, 8'h7A, 8'h7D, 8'h7D, 8'h80,
                               8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h7E};
    logic [7:0]  detV [13] = '{8'h80, 8'h10, 8'h80, 8'h20, 8'h00, 8'h80, 8'h40, 8'h80,
                               8'h80, 8'h40, 8'h20, 8'h10, 8'h02};
    pmbus_host_model pmbus_host_model_inst (.mclk(mclk), .rdData(rdData), .rdValid(rdValid),
        .rdUnsupported(rdUnsupported), .cmdCode(cmdCode), .wrStrobe(wrStrobe),
        .wrHigh(wrHigh), .wrData(wrData), .rdStrobe(rdStrobe), .rdHigh(rdHigh));
    pmbus_status_regs pmbus_status_regs_inst (.mclk(mclk), .rstn(rstn), .clkEn(1'b1),
        .cmdCode(cmdCode), .wrStrobe(wrStrobe), .wrHigh(wrHigh), .wrData(wrData),
        .rdStrobe(rdStrobe), .rdHigh(rdHigh), .rdData(rdData), .rdValid(rdValid),
        .rdUnsupported(rdUnsupported), .convEnable(convEnable), .vOutOv(pins[0]),
        .vOutUv(pins[1]), .iOutOc(pins[2]), .iOutOcw(pins[3]), .vInUv(pins[4]),
        .extOt(pins[5]), .extOtw(pins[6]), .thermalShutdown(pins[7]), .powerGood(powerGood),
        .badCommand(pins[8]), .badData(pins[9]), .pecFail(pins[10]), .memoryFault(pins[11]),
        .otherCommFault(pins[12]), .clearFaults(clearFaults), .softStart(softStart),
        .refTarget(refTarget), .refLevel(refLevel), .nvmSave(nvmSave),
        .nvmRiseWord(nvmRiseWord));
    task automatic cmpv(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] cmd, input logic hi, input logic [7:0] exp);
        pmbus_host_model_inst.rd(cmd, hi, got, uns);
        cmpv($sformatf("read %h.%0d", cmd, hi), {8'h00, exp}, {8'h00, got});
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (80000) @(posedge mclk);
        n_mismatch++;
        $display("MISMATCH watchdog expected done seen timeout");
        report_and_stop;
    end
    initial begin
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        rdchk(`CMD_RISE_TIME, 1'b0, 8'h2B);
        rdchk(`CMD_RISE_TIME, 1'b1, 8'hE0);
        rdchk(`CMD_SUMMARY_BYTE, 1'b0, 8'h00);
        rdchk(`CMD_SUMMARY_WORD, 1'b1, 8'h08);
        for (int i = 0; i < 7; i++) begin
            pmbus_host_model_inst.wr(`CMD_RISE_TIME, 1'b0, snapIn[i]);
            repeat (2) @(negedge mclk);
            rdchk(`CMD_RISE_TIME, 1'b0, snapOut[i]);
        end
        pmbus_host_model_inst.wr(`CMD_RISE_TIME, 1'b1, 8'h00);
        rdchk(`CMD_RISE_TIME, 1'b1, 8'hE0);
        pmbus_host_model_inst.wr(`CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS, 1'b0, 8'hFF);
        rdchk(`CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS, 1'b0, 8'h00);
        pmbus_host_model_inst.wr(`CMD_SAVE_ALL, 1'b0, 8'h00);
        cmpv("save pulse", 16'h0001, {15'h0000, nvmSave});
        cmpv("saved word", 16'hE02B, nvmRiseWord);
        pmbus_host_model_inst.rd(8'h55, 1'b0, got, uns);
        cmpv("unsupported", 16'h0001, {15'h0000, uns});
        for (int i = 0; i < 13; i++) begin
            pins[i] = 1'b1;
            repeat (4) @(negedge mclk);
            pmbus_host_model_inst.rd(`CMD_SUMMARY_BYTE, 1'b0, got, uns);
            cmpv("fault byte", {8'h00, sumB[i]}, {8'h00, got});
            pmbus_host_model_inst.rd(`CMD_SUMMARY_WORD, 1'b0, got, uns);
            cmpv("word low", {8'h00, sumB[i]}, {8'h00, got});
            rdchk(`CMD_SUMMARY_WORD, 1'b1, sumH[i] | 8'h08);
            rdchk(detC[i], 1'b0, detV[i]);
            pins[i] = 1'b0;
            repeat (4) @(negedge mclk);
            clearFaults = 1'b1;
            @(negedge mclk);
            clearFaults = 1'b0;
        end
        rdchk(`CMD_SUMMARY_BYTE, 1'b0, 8'h00);
        convEnable = 1'b0;
        repeat (5) @(negedge mclk);
        rdchk(`CMD_SUMMARY_BYTE, 1'b0, 8'h40);
        convEnable = 1'b1;
        powerGood = 1'b0;
        repeat (4) @(negedge mclk);
        powerGood = 1'b1;
        repeat (4) @(negedge mclk);
        rdchk(`CMD_SUMMARY_WORD, 1'b1, 8'h00);
        pmbus_host_model_inst.wr(`CMD_RISE_TIME, 1'b0, 8'h00);
        softStart = 1'b1;
        refTarget = 12'h0C8;
        repeat (5) @(negedge mclk);
        cmpv("jump level", 16'h00C8, {4'h0, refLevel});
        pmbus_host_model_inst.wr(`CMD_RISE_TIME, 1'b0, 8'h05);
        repeat (3) @(negedge mclk);
        refTarget = 12'h0D2;
        repeat (20) @(negedge mclk);
        cmpv("held level", 16'h00C8, {4'h0, refLevel});
        repeat (52000) @(negedge mclk);
        cmpv("one step", 16'h0001, {15'h0000, refLevel inside {12'h0C9, 12'h0CA}});
        report_and_stop;
    end
endmodule // tb_pmbus_status_regs
